// ==== rtl/pfs_pin_cell.sv ====
// One pad's output path, chosen by its two-bit selection field
`timescale 1ns/1ps
module pfs_pin_cell (
   // Selection
   input wire logic [1:0] fsel,
   input wire logic [7:0] kind_tbl,
   // General I/O side
   input wire logic gpio_o,
   input wire logic gpio_oe,
   // Peripheral drive per code
   input wire logic [3:0] alt_o,
   input wire logic [3:0] alt_oe,
   // Pad side
   output logic pad_o,
   output logic pad_oe,
   output logic pad_analog_en
);

   // Kind of the code now selected
   pfs_pkg::pfs_kind_t kind_sel;

   // Pick the pair of table bits addressed by the field
   always_comb begin
      kind_sel = pfs_pkg::pfs_kind_t'(kind_tbl[{fsel, 1'b0} +: 2]);
   end

   // Steer the pad; input-only and analog codes never drive, so no contention
   always_comb begin
      pad_o = 1'b0;
      pad_oe = 1'b0;
      pad_analog_en = 1'b0;
      unique case (kind_sel)
         pfs_pkg::PFS_K_GPIO: begin
            // Port latch and direction bit keep control
            pad_o = gpio_o;
            pad_oe = gpio_oe;
         end
         pfs_pkg::PFS_K_OUT: begin
            // Peripheral owns value and enable
            pad_o = alt_o[fsel];
            pad_oe = alt_oe[fsel];
         end
         pfs_pkg::PFS_K_IN: begin
            // Pad only listened to
            pad_oe = 1'b0;
         end
         pfs_pkg::PFS_K_ANA: begin
            // Digital buffers off
            pad_analog_en = 1'b1;
         end
      endcase
   end

endmodule

// ==== rtl/pfs_pin_mux.sv ====
// Register file and pad multiplexer for the pin functions of ports B to G
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Functional notes
// RL1: PB3 I/O below 11, timer P2 out at 11
// RL2: Large PB2: I/O, UART2 receive, timer P3 out
// RL3: PB1 UART2 transmit, PB0 comparator 0 at 11
// RL4: PB7 oscillator out; PB6 timer S1, oscillator in
// RL5: PB5 always I/O; PB4 comparator 1 at 11
// RL6: PC3 analog 3; PC2 timer P0, analog 2
// RL7: PC1 I/O, comparator 0, reference, analog 1
// RL8: PC0 I/O, reference input, analog 0
// RL9: PC7 analog 7; PC6 timer S0, analog 6
// RL10: PC5 analog 5; PC4 timer P1, analog 4
// RL11: PD3 analog 11; PD2 timer P2, UART1, analog
// RL12: PD1 UART1 receive; PD0 timer S1, analog 8
// RL13: PD6 timer S2, comparator 1; top bits zero
// RL14: PD5 UART0 transmit; PD4 UART0 receive, timer P3
// RL15: PE3 timer P1, serial-A clock; PE2 data in
// RL16: PE1 timer S0, serial-A data out; PE0 select
// RL17: Port E high: PE4 I/O or supply
// RL18: PF3..PF0 I/O, serial lines, LCD commons
// RL19: PF7 timer S2, UART1, comparator; PF6 likewise
// RL20: PF5 timer P0, crystal in; PF4 crystal out
// RL21: Large variants: PG0/PG1 UART2 at 11
// RL22: Other port G pins always general I/O
// RL23: Fields reset to 00 and are read/write
// RL24: Pads follow field next cycle after write
// RL25: Software disables peripheral before reselecting pin
// RL26: Software also sets the input-source selection
// RL27: Software sets direction bit for shared inputs
module pfs_pin_mux #(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter bit HAS_PORTG = 1'b1
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [pfs_pkg::PFS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [pfs_pkg::PFS_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // General I/O ports, bit port*8+pin
   input wire logic [47:0] gpio_o,
   input wire logic [47:0] gpio_oe,
   output logic [47:0] pin_in_sync,
   // Timer outputs
   input wire logic tmr_p0_out,
   input wire logic tmr_p1_out,
   input wire logic tmr_p2_out,
   input wire logic tmr_p3_out,
   input wire logic tmr_s0_out,
   input wire logic tmr_s1_out,
   input wire logic tmr_s2_out,
   // UART transmitters
   input wire logic uart0_transmit,
   input wire logic uart1_transmit,
   input wire logic uart2_transmit,
   // Comparator outputs
   input wire logic comparator0_output,
   input wire logic comparator1_output,
   // Serial interface A, master outputs
   input wire logic serial_a_clock,
   input wire logic serial_a_data_out,
   input wire logic serial_a_chip_select,
   // Serial interface on port F, each line with its own enable
   input wire logic serial_chip_select,
   input wire logic serial_chip_select_oe,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire logic serial_data_in_pin,
   input wire logic serial_data_in_pin_oe,
   input wire logic serial_clock_pin,
   input wire logic serial_clock_pin_oe,
   // Pads
   input wire logic [47:0] pad_i,
   output logic [47:0] pad_o,
   output logic [47:0] pad_oe,
   output logic [47:0] pad_analog_en
);

   // Port G is present on every large part
   if (LARGE_VARIANT && !HAS_PORTG) begin : g_bad_variant
      $error("pfs_pin_mux: large variant requires port G");
   end

   // Selection registers, implemented bits only
   logic [7:0] sel_q [pfs_pkg::PFS_NUM_REGS];
   // Write channel holding state
   logic aw_held_q;
   logic [pfs_pkg::PFS_ADDR_W-1:0] aw_addr_q;
   logic w_held_q;
   logic [7:0] w_data_q;
   logic w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   // Read channel state
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   // Decode results
   logic wr_hit;
   logic [3:0] wr_idx;
   logic rd_hit;
   logic [3:0] rd_idx;
   logic wr_fire;
   // Pad input synchronisers
   logic [47:0] pad_meta_q;
   logic [47:0] pad_sync_q;
   // Per-pin kind table and peripheral drive
   logic [7:0] kind_eff [pfs_pkg::PFS_NUM_PINS];
   logic [3:0] alt_o [pfs_pkg::PFS_NUM_PINS];
   logic [3:0] alt_oe [pfs_pkg::PFS_NUM_PINS];

   // Protection bits carry no meaning here
   logic unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8], s_axi_wstrb[3:1]};

   // Address decode for both channels; port G hits only where the port exists
   always_comb begin
      wr_hit = 1'b0;
      wr_idx = 4'h0;
      rd_hit = 1'b0;
      rd_idx = 4'h0;
      for (int i = 0; i < pfs_pkg::PFS_NUM_REGS; i++) begin
         if ((i < pfs_pkg::PFS_FIRST_PORTG_REG) || HAS_PORTG) begin
            if (aw_addr_q == pfs_pkg::PFS_REG_OFS[i]) begin
               wr_hit = 1'b1;
               wr_idx = 4'(i);
            end
            if (s_axi_araddr == pfs_pkg::PFS_REG_OFS[i]) begin
               rd_hit = 1'b1;
               rd_idx = 4'(i);
            end
         end
      end
   end

   // Ready while the slot is free and no response waits
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready = !w_held_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;

   // Both halves of a write are present
   assign wr_fire = aw_held_q && w_held_q;

   // Capture write address; either order with the data is accepted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end
   end

   // Capture write data; only byte lane 0 holds register bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         w_data_q <= 8'h00;
         w_strb_q <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata[7:0];
         w_strb_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end
   end

   // Write response: one cycle after both halves are held, two after the later half is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= pfs_pkg::PFS_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? pfs_pkg::PFS_RESP_OKAY : pfs_pkg::PFS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // Selection fields; unimplemented bits are masked so they stay zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < pfs_pkg::PFS_NUM_REGS; i++) begin
            sel_q[i] <= pfs_pkg::PFS_REG_RST; // RL23
         end
      end else if (wr_fire && wr_hit && w_strb_q) begin
         // A missing lane strobe leaves the register untouched
         sel_q[wr_idx] <= w_data_q & pfs_pkg::PFS_REG_MASK[wr_idx]; // RL13 RL17 RL23
      end
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= pfs_pkg::PFS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         if (rd_hit) begin
            rdata_q <= {24'h00_0000, sel_q[rd_idx]}; // RL23
            rresp_q <= pfs_pkg::PFS_RESP_OKAY;
         end else begin
            // Unmapped: zero data and an error
            rdata_q <= 32'h0000_0000;
            rresp_q <= pfs_pkg::PFS_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Pad inputs cross two flops before anything reads them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pad_meta_q <= '0;
         pad_sync_q <= '0;
      end else begin
         pad_meta_q <= pad_i;
         pad_sync_q <= pad_meta_q;
      end
   end

   // Peripheral inputs pick their source pin elsewhere; they all see this copy
   assign pin_in_sync = pad_sync_q; // RL26 RL27

   // Kind table with the large-variant UART2 pins patched in
   always_comb begin
      for (int p = 0; p < pfs_pkg::PFS_NUM_PINS; p++) begin
         kind_eff[p] = pfs_pkg::PFS_KIND_TBL[p]; // RL5 RL22
      end
      if (LARGE_VARIANT) begin
         kind_eff[pfs_pkg::PFS_PIN_PB1] = pfs_pkg::PFS_KIND_LG_PB1; // RL3
         kind_eff[pfs_pkg::PFS_PIN_PB2] = pfs_pkg::PFS_KIND_LG_PB2; // RL2
         kind_eff[pfs_pkg::PFS_PIN_PG0] = pfs_pkg::PFS_KIND_LG_PG0; // RL21
         kind_eff[pfs_pkg::PFS_PIN_PG1] = pfs_pkg::PFS_KIND_LG_PG1; // RL21
      end
   end

   // Peripheral drive per pin and code; unused entries are never selected
   always_comb begin
      for (int p = 0; p < pfs_pkg::PFS_NUM_PINS; p++) begin
         alt_o[p] = 4'h0;
         alt_oe[p] = 4'hF;
      end
      // Port B
      alt_o[0][3] = comparator0_output; // RL3
      alt_o[1][3] = uart2_transmit; // RL3
      alt_o[2][3] = tmr_p3_out; // RL2
      alt_o[3][3] = tmr_p2_out; // RL1
      alt_o[4][3] = comparator1_output; // RL5
      alt_o[6][2] = tmr_s1_out; // RL4
      // Port C
      alt_o[9][1] = comparator0_output; // RL7
      alt_o[10][2] = tmr_p0_out; // RL6
      alt_o[12][2] = tmr_p1_out; // RL10
      alt_o[14][2] = tmr_s0_out; // RL9
      // Port D
      alt_o[16][2] = tmr_s1_out; // RL12
      alt_o[18][1] = tmr_p2_out; // RL11
      alt_o[18][2] = uart1_transmit; // RL11
      alt_o[20][2] = tmr_p3_out; // RL14
      alt_o[21][2] = uart0_transmit; // RL14
      alt_o[22][2] = tmr_s2_out; // RL13
      alt_o[22][3] = comparator1_output; // RL13
      // Port E
      alt_o[24][3] = serial_a_chip_select; // RL16
      alt_o[25][2] = tmr_s0_out; // RL16
      alt_o[25][3] = serial_a_data_out; // RL16
      alt_o[27][2] = tmr_p1_out; // RL15
      alt_o[27][3] = serial_a_clock; // RL15
      // Port F serial lines may float or go open-drain under the peripheral
      alt_o[32][2] = serial_chip_select; // RL18
      alt_oe[32][2] = serial_chip_select_oe; // RL18
      alt_o[33][2] = serial_data_out; // RL18
      alt_oe[33][2] = serial_data_out_oe; // RL18
      alt_o[34][2] = serial_data_in_pin; // RL18
      alt_oe[34][2] = serial_data_in_pin_oe; // RL18
      alt_o[35][2] = serial_clock_pin; // RL18
      alt_oe[35][2] = serial_clock_pin_oe; // RL18
      alt_o[37][2] = tmr_p0_out; // RL20
      alt_o[39][1] = uart1_transmit; // RL19
      alt_o[39][2] = tmr_s2_out; // RL19
      // Port G
      alt_o[41][3] = uart2_transmit; // RL21
   end

   // One cell per pin; field of pin p sits in register p/4 at bits (p%4)*2.
   // The pads follow the registers directly, so a write shows on the next
   // cycle; software must have quiesced the old peripheral first.
   for (genvar p = 0; p < pfs_pkg::PFS_NUM_PINS; p++) begin : g_pin
      pfs_pin_cell u_cell (
         .fsel(sel_q[p / 4][(p % 4) * pfs_pkg::PFS_FIELD_W +: pfs_pkg::PFS_FIELD_W]), // RL24 RL25
         .kind_tbl(kind_eff[p]), // RL6 RL7 RL8 RL9 RL10 RL11 RL12 RL14
         .gpio_o(gpio_o[p]),
         .gpio_oe(gpio_oe[p]),
         .alt_o(alt_o[p]),
         .alt_oe(alt_oe[p]),
         .pad_o(pad_o[p]),
         .pad_oe(pad_oe[p]),
         .pad_analog_en(pad_analog_en[p]) // RL4 RL8 RL15 RL16 RL17 RL18 RL19 RL20
      );
   end

endmodule

// ==== rtl/pfs_pkg.sv ====
// Constants, register map and pin-function tables of the port function selector
package pfs_pkg;

   // Register bus geometry
   localparam int PFS_ADDR_W = 12;
   localparam int PFS_NUM_REGS = 12;
   localparam int PFS_NUM_PINS = 48;
   localparam int PFS_FIELD_W = 2;

   // Byte offsets of the selection registers, one aligned word each
   localparam logic [11:0] PFS_OFS_PORTB_LOW = 12'h000;
   localparam logic [11:0] PFS_OFS_PORTB_HIGH = 12'h004;
   localparam logic [11:0] PFS_OFS_PORTC_LOW = 12'h008;
   localparam logic [11:0] PFS_OFS_PORTC_HIGH = 12'h00C;
   localparam logic [11:0] PFS_OFS_PORTD_LOW = 12'h010;
   localparam logic [11:0] PFS_OFS_PORTD_HIGH = 12'h014;
   localparam logic [11:0] PFS_OFS_PORTE_LOW = 12'h018;
   localparam logic [11:0] PFS_OFS_PORTE_HIGH = 12'h01C;
   localparam logic [11:0] PFS_OFS_PORTF_LOW = 12'h020;
   localparam logic [11:0] PFS_OFS_PORTF_HIGH = 12'h024;
   localparam logic [11:0] PFS_OFS_PORTG_LOW = 12'h028;
   localparam logic [11:0] PFS_OFS_PORTG_HIGH = 12'h02C;

   // Offsets in register order
   localparam logic [11:0] PFS_REG_OFS [PFS_NUM_REGS] = '{
      PFS_OFS_PORTB_LOW, PFS_OFS_PORTB_HIGH, PFS_OFS_PORTC_LOW, PFS_OFS_PORTC_HIGH,
      PFS_OFS_PORTD_LOW, PFS_OFS_PORTD_HIGH, PFS_OFS_PORTE_LOW, PFS_OFS_PORTE_HIGH,
      PFS_OFS_PORTF_LOW, PFS_OFS_PORTF_HIGH, PFS_OFS_PORTG_LOW, PFS_OFS_PORTG_HIGH};

   // Implemented bits; port D high keeps bits 5..0, port E high keeps bits 1..0
   localparam logic [7:0] PFS_REG_MASK [PFS_NUM_REGS] = '{
      8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'h03, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

   // Power-on value of every selection register
   localparam logic [7:0] PFS_REG_RST = 8'h00;

   // Index of the first port G register; absent parts answer with an error there
   localparam int PFS_FIRST_PORTG_REG = 10;

   // Bus answers
   localparam logic [1:0] PFS_RESP_OKAY = 2'h0;
   localparam logic [1:0] PFS_RESP_SLVERR = 2'h2;

   // What a pad does for one field code
   typedef enum logic [1:0] {
      PFS_K_GPIO = 2'h0,  // General I/O, digital inputs share it
      PFS_K_OUT = 2'h1,   // Driven by a peripheral
      PFS_K_IN = 2'h2,    // Peripheral input only, pad not driven
      PFS_K_ANA = 2'h3    // Analog or special pad, digital path off
   } pfs_kind_t;

   // Per pin, kind of codes 3..0 packed as {c3,c2,c1,c0}; pins are port*8+bit
   localparam logic [7:0] PFS_KIND_TBL [PFS_NUM_PINS] = '{
      // Port B, base variant
      8'h40, 8'h00, 8'h40, 8'h40, 8'h40, 8'h00, 8'hD0, 8'hC0,
      // Port C
      8'hF0, 8'hF4, 8'hD0, 8'hC0, 8'hD0, 8'hC0, 8'hD0, 8'hC0,
      // Port D, pin 7 has no field
      8'hD0, 8'hE0, 8'hD4, 8'hC0, 8'hD8, 8'hD0, 8'h50, 8'h00,
      // Port E, pins 7..5 have no field
      8'h40, 8'h50, 8'h80, 8'h50, 8'hC0, 8'h00, 8'h00, 8'h00,
      // Port F
      8'hD0, 8'hD0, 8'hD0, 8'hD0, 8'hC0, 8'hD0, 8'hE0, 8'hD4,
      // Port G, general I/O on small variants
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // Large-variant replacements for the pins that gain UART2
   localparam int PFS_PIN_PB1 = 1;
   localparam int PFS_PIN_PB2 = 2;
   localparam int PFS_PIN_PG0 = 40;
   localparam int PFS_PIN_PG1 = 41;
   localparam logic [7:0] PFS_KIND_LG_PB1 = 8'h40;
   localparam logic [7:0] PFS_KIND_LG_PB2 = 8'h60;
   localparam logic [7:0] PFS_KIND_LG_PG0 = 8'h80;
   localparam logic [7:0] PFS_KIND_LG_PG1 = 8'h40;

endpackage

// ==== verification/pfs_pin_mux_assertions.sv ====
// Bus handshake, reset and pad timing checks for the port function selector
`timescale 1ns/1ps
module pfs_pin_mux_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels
   input wire logic [pfs_pkg::PFS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pads and general I/O
   input wire logic [47:0] gpio_o,
   input wire logic [47:0] gpio_oe,
   input wire logic [47:0] pin_in_sync,
   input wire logic [47:0] pad_i,
   input wire logic [47:0] pad_o,
   input wire logic [47:0] pad_oe,
   input wire logic [47:0] pad_analog_en
);
   // One clock domain: clocking and reset declared once
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Both halves held one cycle, then the answer is registered: seen two edges on
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   // Write answer stands until taken
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer dropped early");
   // Read answer one edge after the address is taken
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // Read data stands until taken
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer changed early");
   // Registers are one byte, upper bits read zero
   a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   // No write accepted while an answer waits
   a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during answer");
   // Writes above the map are refused, answer two edges after the take
   a_wr_unmapped: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr > 12'h02C |-> ##2 s_axi_bresp == pfs_pkg::PFS_RESP_SLVERR)
      else $error("unmapped write not refused");
   // Right after reset every pad is general I/O
   a_pads_reset: assert property (!$past(aresetn) |-> pad_o == gpio_o && pad_oe == gpio_oe
      && pad_analog_en == 48'h000000000000) else $error("pad not in general I/O after reset");
   // Pad input reaches the core after exactly two flops
   a_sync_two: assert property ($past(aresetn, 2) && $past(aresetn) |->
      pin_in_sync == $past(pad_i, 2)) else $error("input sync depth wrong");

   // Main scenarios
   c_refused: cover property (s_axi_bvalid && s_axi_bresp == pfs_pkg::PFS_RESP_SLVERR);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_analog: cover property (pad_analog_en != 48'h000000000000);
endmodule

bind pfs_pin_mux pfs_pin_mux_chk chk_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .gpio_o, .gpio_oe, .pin_in_sync, .pad_i, .pad_o, .pad_oe, .pad_analog_en);

// ==== verification/tb.sv ====
// Self-checking bench for the port function selector
`timescale 1ns/1ps
module tb;
   // Clock, reset and bus master signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [pfs_pkg::PFS_ADDR_W-1:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   // Pad side; gpio low and driving so each kind looks different
   logic [47:0] gpio_o = 48'h000000000000, gpio_oe = 48'hFFFFFFFFFFFF, pad_i = 48'h000000000000;
   logic [47:0] pin_in_sync, pad_o, pad_oe, pad_analog_en;
   // Common peripheral value and port F serial enable
   logic pv = 1'b1, soe = 1'b1;
   int n_fail = 0, cmp_count = 0;
   // Expected kind per pin and code: 0 gpio, 1 out, 2 input, 3 analog
   logic [7:0] kind_exp [48] = '{
      8'h40, 8'h40, 8'h60, 8'h40, 8'h40, 8'h00, 8'hD0, 8'hC0,
      8'hF0, 8'hF4, 8'hD0, 8'hC0, 8'hD0, 8'hC0, 8'hD0, 8'hC0,
      8'hD0, 8'hE0, 8'hD4, 8'hC0, 8'hD8, 8'hD0, 8'h50, 8'h00,
      8'h40, 8'h50, 8'h80, 8'h50, 8'hC0, 8'h00, 8'h00, 8'h00,
      8'hD0, 8'hD0, 8'hD0, 8'hD0, 8'hC0, 8'hD0, 8'hE0, 8'hD4,
      8'h80, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   pfs_pin_mux dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gpio_o,
      .gpio_oe, .pin_in_sync, .tmr_p0_out(pv), .tmr_p1_out(pv), .tmr_p2_out(pv),
      .tmr_p3_out(pv), .tmr_s0_out(pv), .tmr_s1_out(pv), .tmr_s2_out(pv), .uart0_transmit(pv),
      .uart1_transmit(pv), .uart2_transmit(pv), .comparator0_output(pv),
      .comparator1_output(pv), .serial_a_clock(pv), .serial_a_data_out(pv),
      .serial_a_chip_select(pv), .serial_chip_select(pv), .serial_chip_select_oe(soe),
      .serial_data_out(pv), .serial_data_out_oe(soe), .serial_data_in_pin(pv),
      .serial_data_in_pin_oe(soe), .serial_clock_pin(pv), .serial_clock_pin_oe(soe),
      .pad_i, .pad_o, .pad_oe, .pad_analog_en);

   // Clock at 40 MHz
   always #12.5 aclk = ~aclk;
   // Pads keep moving to exercise the input synchroniser
   always @(posedge aclk) begin
      pad_i <= {pad_i[46:0], ~pad_i[47]};
   end

   // Report counts and verdict, then stop
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Compare with case equality so unknowns never match
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // A bus wait that runs out ends the run
   task automatic hang();
      n_fail++;
      $display("MISMATCH t=%0t bus answer never came", $time);
      finish_test();
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic bus_wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
      output logic [1:0] r);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (i == 40)
         hang();
   endtask

   // Read: address held until taken, data taken at the answer edge
   task automatic bus_rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata[7:0];
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (i == 40)
         hang();
   endtask

   // Every register reads zero after reset and pads follow general I/O
   task automatic t_reset();
      logic [7:0] d;
      logic [1:0] r;
      for (int k = 0; k < 12; k++) begin
         bus_rd(pfs_pkg::PFS_REG_OFS[k], d, r);
         chk(48'(d), 48'h0, "reset value");
         chk(48'(r), 48'(pfs_pkg::PFS_RESP_OKAY), "reset read resp");
      end
      gpio_o <= 48'h5A5A5A5A5A5A;
      gpio_oe <= 48'h0F0F0F0F0F0F;
      @(posedge aclk);
      #1;
      chk(pad_o, 48'h5A5A5A5A5A5A, "gpio data");
      chk(pad_oe, 48'h0F0F0F0F0F0F, "gpio enable");
      gpio_o <= 48'h000000000000;
      gpio_oe <= 48'hFFFFFFFFFFFF;
   endtask

   // Every code of every field: pad kind right after the write, then read-back
   task automatic t_kinds();
      logic [7:0] d, v, m;
      logic [1:0] r, k;
      int p;
      for (int g = 0; g < 12; g++) begin
         for (int c = 0; c < 4; c++) begin
            v = {4{2'(c)}};
            m = (g == 5) ? 8'h3F : (g == 7) ? 8'h03 : 8'hFF;
            bus_wr(pfs_pkg::PFS_REG_OFS[g], v, 4'h1, r);
            for (int n = 0; n < 4; n++) begin
               p = (g / 2) * 8 + (g % 2) * 4 + n;
               k = kind_exp[p][2*c +: 2];
               chk(48'(pad_oe[p]), 48'(k < 2), "pad enable");
               chk(48'(pad_analog_en[p]), 48'(k == 3), "pad analog");
               if (k < 2)
                  chk(48'(pad_o[p]), 48'(k == 1), "pad data");
               else
                  chk(48'(pad_o[p]), 48'h0, "pad idle");
            end
            bus_rd(pfs_pkg::PFS_REG_OFS[g], d, r);
            chk(48'({d, r}), 48'({v & m, pfs_pkg::PFS_RESP_OKAY}), "read-back");
         end
      end
   endtask

   // Unmapped place is refused, a write with no byte strobe changes nothing
   task automatic t_err();
      logic [7:0] d;
      logic [1:0] r;
      bus_wr(12'h030, 8'hFF, 4'h1, r);
      chk(48'(r), 48'(pfs_pkg::PFS_RESP_SLVERR), "unmapped write");
      bus_rd(12'h030, d, r);
      chk(48'({d, r}), 48'({8'h00, pfs_pkg::PFS_RESP_SLVERR}), "unmapped read");
      bus_wr(pfs_pkg::PFS_OFS_PORTB_LOW, 8'h00, 4'h0, r);
      bus_rd(pfs_pkg::PFS_OFS_PORTB_LOW, d, r);
      chk(48'(d), 48'hFF, "strobe off");
   endtask

   // Peripheral drive follows; pins released, then a second reset clears port B low
   task automatic t_follow();
      logic [7:0] d;
      logic [1:0] r;
      bus_wr(pfs_pkg::PFS_OFS_PORTF_LOW, 8'hAA, 4'h1, r);
      pv <= 1'b0;
      soe <= 1'b0;
      @(posedge aclk);
      #1;
      chk(48'(pad_o[0]), 48'h0, "comparator follow");
      chk(48'(pad_oe[35:32]), 48'h0, "serial enable");
      bus_wr(pfs_pkg::PFS_OFS_PORTF_LOW, 8'h00, 4'h1, r);
      chk(48'(pad_oe[35:32]), 48'hF, "serial released");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      bus_rd(pfs_pkg::PFS_OFS_PORTB_LOW, d, r);
      chk(48'(d), 48'h0, "second reset");
   endtask

   // Main sequence
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_kinds();
      t_err();
      t_follow();
      finish_test();
   end
endmodule
